// File: design/cgc_pkg.sv
// Behaviour
// R01: three profile pins choose one of six stored configurations, codes 000 to 101.
// R02: the controlling party never drives the profile pins to codes 110 or 111; here the bench drives both with allow_rsvd_i set.
// R03: the host may rewrite stored configurations while running; changes apply at once.
// R04: primary bit swaps crystal and aux roles; source choice low picks primary.
// R05: crystal bypass bit turns off the crystal oscillator and uses input directly.
// R06: switchover field 0x manual, 10 automatic one way, 11 auto-revertive.
// R07: pin polarity bit sets shutdown/enable pin polarity, default zero; here it only sets the gating level, shutdown always takes pin high.
// R08: pin function bit picks output gating or PLL shutdown role for the pin.
// R09: output high-Z without presence bit; gate bit lets the pin suspend it; here global shutdown drives absent outputs too.
// R10: function bit set and pin high shuts everything down, all outputs suspended.
// R11: the serial interface answers at fixed seven-bit address 1101010.
// R12: resistor code steps 4.0 kilohm, pump current code steps 6 microamps.
// R13: reserved profile codes keep the last valid configuration applied.
package cgc_pkg;
    localparam int NUM_OUT = 5;
    localparam int NUM_CFG = 6;
    localparam logic [2:0] LAST_CFG = 3'h5;
    localparam logic [6:0] DEV_ADDR = 7'h6a;
    localparam logic [16:0] RES_STEP_OHM = 17'h0_0fa0;
    localparam logic [5:0] PUMP_STEP_UA = 6'h06;
    localparam logic [7:0] PIN_POLARITY_ADDR = 8'h02;
    localparam logic [1:0] SW_AUTO = 2'h2;
    localparam int PIN_W = 7;

    typedef enum logic {
        CGC_REF_PRI,
        CGC_REF_SEC
    } cgc_ref_sel_t;

    typedef struct packed {
        logic crystal_bypass_bit;
        logic primary_source_bit;
        logic [1:0] switchover_mode_field;
        logic pin_polarity_bit;
        logic pin_function_bit;
        logic [NUM_OUT-1:0] output_present_bit;
        logic [NUM_OUT-1:0] output_gate_bit;
        logic [3:0] loop_resistor_code;
        logic zero_cap_bit;
        logic [2:0] pump_current_code;
    } cgc_cfg_t;

    localparam cgc_cfg_t CFG_RESET = '{
        crystal_bypass_bit: 1'b0,
        primary_source_bit: 1'b0,
        switchover_mode_field: 2'h0,
        pin_polarity_bit: 1'b0,
        pin_function_bit: 1'b0,
        output_present_bit: 5'h1f,
        output_gate_bit: 5'h00,
        loop_resistor_code: 4'h0,
        zero_cap_bit: 1'b0,
        pump_current_code: 3'h0
    };

    typedef struct packed {
        logic [NUM_OUT-1:0] drive_en;
        logic [NUM_OUT-1:0] suspend;
    } cgc_out_ctl_t;

    typedef struct packed {
        logic [16:0] loop_res_ohm;
        logic [5:0] pump_ua;
        logic zero_cap;
    } cgc_filter_t;
endpackage : cgc_pkg

// File: design/cgc_ctrl.sv
`timescale 1ns/1ps
module cgc_ctrl (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [2:0] profile_pick_pins_i,
    input wire logic source_choice_input_i,
    input wire logic shutdown_enable_pin_i,
    input wire logic primary_fail_i,
    input wire logic secondary_fail_i,
    input wire logic cfg_wr_i,
    input wire logic [2:0] cfg_wr_idx_i,
    input wire cgc_pkg::cgc_cfg_t cfg_wr_data_i,
    input wire logic host_addr_vld_i,
    input wire logic [6:0] host_addr_i,
    output logic [2:0] active_profile_o,
    output logic ref_is_aux_o,
    output logic crystal_osc_en_o,
    output logic pll_shutdown_o,
    output cgc_pkg::cgc_out_ctl_t out_ctl_o,
    output cgc_pkg::cgc_filter_t filter_o,
    output logic addr_match_o
);
    // every check below runs on the one clock and stays quiet while reset is held
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // pin synchronisers
    logic [cgc_pkg::PIN_W-1:0] pins_raw;
    logic [cgc_pkg::PIN_W-1:0] sync1_q;
    logic [cgc_pkg::PIN_W-1:0] sync1_d;
    logic [cgc_pkg::PIN_W-1:0] sync2_q;
    logic [cgc_pkg::PIN_W-1:0] sync2_d;
    logic [2:0] pick_s;
    logic choice_s;
    logic pin_s;
    logic pri_fail_s;
    logic sec_fail_s;

    assign pins_raw = {secondary_fail_i, primary_fail_i, shutdown_enable_pin_i,
                       source_choice_input_i, profile_pick_pins_i};
    assign {sec_fail_s, pri_fail_s, pin_s, choice_s, pick_s} = sync2_q;

    always_comb begin
        sync1_d = pins_raw;
        sync2_d = sync1_q;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // two stages so a metastable pin level never reaches the decode
    // R08: pin reaches role logic
    sync_pipe_a: assert property (1'b1 // R08
        |=> ##1 pin_s == $past(shutdown_enable_pin_i, 2))
        else $error("pin level not carried through two stages");

    // ==========================================================
    // configuration store and profile choice
    cgc_pkg::cgc_cfg_t cfg_mem_q [cgc_pkg::NUM_CFG];
    cgc_pkg::cgc_cfg_t cfg_mem_d [cgc_pkg::NUM_CFG];
    logic [2:0] prof_q;
    logic [2:0] prof_d;
    cgc_pkg::cgc_cfg_t cur;

    // live view: a host write to the active slot shows up the next cycle
    assign cur = cfg_mem_q[prof_q];

    always_comb begin
        cfg_mem_d = cfg_mem_q;
        // R03: on-the-fly rewrite
        if (cfg_wr_i && cfg_wr_idx_i <= cgc_pkg::LAST_CFG) begin
            cfg_mem_d[cfg_wr_idx_i] = cfg_wr_data_i;
        end
        prof_d = prof_q;
        // R01: pick decode
        // R13: reserved codes hold the last valid profile
        if (pick_s <= cgc_pkg::LAST_CFG) begin
            prof_d = pick_s;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < cgc_pkg::NUM_CFG; i++) begin
                cfg_mem_q[i] <= cgc_pkg::CFG_RESET;
            end
            prof_q <= '0;
        end else begin
            cfg_mem_q <= cfg_mem_d;
            prof_q <= prof_d;
        end
    end

    // ==========================================================
    // store checks
    // R01: valid code applied
    prof_valid_a: assert property (pick_s <= cgc_pkg::LAST_CFG // R01
        |=> ##1 active_profile_o == $past(pick_s, 2))
        else $error("valid profile code not applied");

    // R13: reserved code held
    prof_hold_a: assert property (pick_s > cgc_pkg::LAST_CFG // R13
        |=> $stable(prof_q))
        else $error("reserved profile code changed the profile");

    // R03: host write stored
    cfg_write_a: assert property (cfg_wr_i && cfg_wr_idx_i <= cgc_pkg::LAST_CFG // R03
        |=> cfg_mem_q[$past(cfg_wr_idx_i)] == $past(cfg_wr_data_i))
        else $error("host write not stored");

    // R03: active slot rewrite applies
    live_apply_a: assert property (cfg_wr_i && cfg_wr_idx_i == prof_q && pick_s == prof_q // R03
        |=> ##1 filter_o.zero_cap == $past(cfg_wr_data_i.zero_cap_bit, 2))
        else $error("rewrite of active slot not applied");

    // ==========================================================
    // reference switchover
    cgc_pkg::cgc_ref_sel_t sel_q;
    cgc_pkg::cgc_ref_sel_t sel_d;

    always_comb begin
        sel_d = sel_q;
        // R06: manual follows the pin; auto modes react to input failure
        if (cur.switchover_mode_field[1] == 1'b0) begin
            sel_d = choice_s ? cgc_pkg::CGC_REF_SEC : cgc_pkg::CGC_REF_PRI;
        end else begin
            case (sel_q)
                cgc_pkg::CGC_REF_PRI: begin
                    if (pri_fail_s && !sec_fail_s) begin
                        sel_d = cgc_pkg::CGC_REF_SEC;
                    end
                end
                cgc_pkg::CGC_REF_SEC: begin
                    // plain auto never goes back, so a dead secondary stays selected
                    if (cur.switchover_mode_field[0] && sec_fail_s && !pri_fail_s) begin
                        sel_d = cgc_pkg::CGC_REF_PRI;
                    end
                end
                default: sel_d = cgc_pkg::CGC_REF_PRI;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sel_q <= cgc_pkg::CGC_REF_PRI;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ==========================================================
    // switchover checks
    // R06: manual follows pin
    manual_mode_a: assert property (!cur.switchover_mode_field[1] && $stable(cur.switchover_mode_field) // R06
        |=> sel_q == ($past(choice_s) ? cgc_pkg::CGC_REF_SEC : cgc_pkg::CGC_REF_PRI))
        else $error("manual mode not following source choice");

    // R06: plain auto never returns
    auto_oneway_a: assert property (cur.switchover_mode_field == cgc_pkg::SW_AUTO // R06
        && sel_q == cgc_pkg::CGC_REF_SEC |=> sel_q == cgc_pkg::CGC_REF_SEC)
        else $error("automatic mode reverted");

    // R06: auto leaves failed primary
    auto_fail_a: assert property (cur.switchover_mode_field[1] && sel_q == cgc_pkg::CGC_REF_PRI // R06
        && pri_fail_s && !sec_fail_s |=> sel_q == cgc_pkg::CGC_REF_SEC)
        else $error("failed primary kept in automatic mode");

    // R06: no failure, no switch
    auto_hold_a: assert property (cur.switchover_mode_field[1] && !pri_fail_s && !sec_fail_s // R06
        |=> $stable(sel_q))
        else $error("automatic mode switched with both inputs good");

    // R06: revertive mode returns
    revert_back_a: assert property (cur.switchover_mode_field[1] && cur.switchover_mode_field[0] // R06
        && sel_q == cgc_pkg::CGC_REF_SEC && sec_fail_s && !pri_fail_s |=> sel_q == cgc_pkg::CGC_REF_PRI)
        else $error("revertive mode did not return");

    // ==========================================================
    // output control and decode
    logic aux_d;
    logic osc_en_d;
    logic pll_shdn_d;
    logic global_shdn;
    logic disable_lvl;
    cgc_pkg::cgc_out_ctl_t out_ctl_d;
    cgc_pkg::cgc_filter_t filter_d;
    logic match_d;

    always_comb begin
        // R04: primary bit flips which input counts as primary
        aux_d = (sel_q == cgc_pkg::CGC_REF_SEC) ^ cur.primary_source_bit;
        // R05: bypass switches the oscillator off
        osc_en_d = !cur.crystal_bypass_bit;
        // R08: pin as PLL shutdown
        // R10: global shutdown
        global_shdn = cur.pin_function_bit && pin_s;
        pll_shdn_d = global_shdn;
        // R07: polarity decides which pin level disables a gated output
        disable_lvl = pin_s ^ cur.pin_polarity_bit;
        // R09: presence and gate per output
        out_ctl_d.drive_en = cur.output_present_bit;
        out_ctl_d.suspend = cur.output_present_bit & cur.output_gate_bit & {cgc_pkg::NUM_OUT{disable_lvl}};
        if (global_shdn) begin
            out_ctl_d.drive_en = '1;
            out_ctl_d.suspend = '1;
        end
        // R12: binary weighted steps
        filter_d.loop_res_ohm = 17'(cur.loop_resistor_code * cgc_pkg::RES_STEP_OHM);
        filter_d.pump_ua = 6'(cur.pump_current_code * cgc_pkg::PUMP_STEP_UA);
        filter_d.zero_cap = cur.zero_cap_bit;
        // R11: fixed slave address
        match_d = host_addr_vld_i && (host_addr_i == cgc_pkg::DEV_ADDR);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            active_profile_o <= '0;
            ref_is_aux_o <= 1'b0;
            crystal_osc_en_o <= 1'b1;
            pll_shutdown_o <= 1'b0;
            out_ctl_o <= '0;
            filter_o <= '0;
            addr_match_o <= 1'b0;
        end else begin
            active_profile_o <= prof_q;
            ref_is_aux_o <= aux_d;
            crystal_osc_en_o <= osc_en_d;
            pll_shutdown_o <= pll_shdn_d;
            out_ctl_o <= out_ctl_d;
            filter_o <= filter_d;
            addr_match_o <= match_d;
        end
    end

    // ==========================================================
    // output checks

    // R04: reference input pick
    ref_pick_a: assert property (1'b1 // R04
        |=> ref_is_aux_o == ($past(sel_q == cgc_pkg::CGC_REF_SEC) != $past(cur.primary_source_bit)))
        else $error("wrong reference input");

    // R05: bypass stops oscillator
    bypass_osc_a: assert property (1'b1 // R05
        |=> crystal_osc_en_o == !$past(cur.crystal_bypass_bit))
        else $error("oscillator enable wrong");

    // R09: absent output floats
    hiz_out_a: assert property (!global_shdn // R09
        |=> out_ctl_o.drive_en == $past(cur.output_present_bit)
        && (out_ctl_o.suspend & ~out_ctl_o.drive_en) == '0)
        else $error("absent output not high-Z");

    // R07: polarity picks active level
    gate_pol_a: assert property (!global_shdn && cur.output_present_bit[0] && cur.output_gate_bit[0] // R07
        |=> out_ctl_o.suspend[0] == ($past(pin_s) != $past(cur.pin_polarity_bit)))
        else $error("pin polarity not honoured");

    // R09: ungated output stays on
    gate_off_a: assert property (!global_shdn // R09
        |=> (out_ctl_o.suspend & ~$past(cur.output_gate_bit)) == '0)
        else $error("ungated output suspended");

    // R10: global shutdown
    global_shdn_a: assert property (cur.pin_function_bit && pin_s // R10
        |=> pll_shutdown_o && out_ctl_o.suspend == '1)
        else $error("global shutdown missed");

    // R10: shutdown overrides presence
    global_drive_a: assert property (global_shdn // R10
        |=> out_ctl_o.drive_en == '1)
        else $error("output floated during global shutdown");

    // R08: gating role spares PLLs
    pll_role_a: assert property (!cur.pin_function_bit // R08
        |=> !pll_shutdown_o)
        else $error("pin shut PLLs while in gating role");

    // R08: idle pin keeps PLLs
    pll_on_a: assert property (cur.pin_function_bit && !pin_s // R08
        |=> !pll_shutdown_o)
        else $error("PLLs shut with pin low");

    // R12: binary weighted decode
    decode_a: assert property (1'b1 // R12
        |=> filter_o.loop_res_ohm == 17'($past(cur.loop_resistor_code) * cgc_pkg::RES_STEP_OHM)
        && filter_o.pump_ua == 6'($past(cur.pump_current_code) * cgc_pkg::PUMP_STEP_UA)
        && filter_o.zero_cap == $past(cur.zero_cap_bit))
        else $error("loop filter decode wrong");

    // R11: own address seen
    addr_hit_a: assert property (host_addr_vld_i && host_addr_i == cgc_pkg::DEV_ADDR // R11
        |=> addr_match_o)
        else $error("own address not matched");

    // R11: foreign address ignored
    addr_miss_a: assert property (!(host_addr_vld_i && host_addr_i == cgc_pkg::DEV_ADDR) // R11
        |=> !addr_match_o)
        else $error("foreign address matched");

    failover_c: cover property (sel_q == cgc_pkg::CGC_REF_PRI ##1 sel_q == cgc_pkg::CGC_REF_SEC);
    revert_c: cover property (sel_q == cgc_pkg::CGC_REF_SEC ##1 sel_q == cgc_pkg::CGC_REF_PRI);
    reserved_c: cover property (pick_s > cgc_pkg::LAST_CFG ##1 pick_s <= cgc_pkg::LAST_CFG);
    shutdown_c: cover property (pll_shutdown_o);
    live_wr_c: cover property (cfg_wr_i && cfg_wr_idx_i == prof_q);
endmodule : cgc_ctrl

// File: testbench/cgc_board_model.sv
`timescale 1ns/1ps
// ==========================================
// board pin model
module cgc_board_model (
    input wire logic [2:0] pick_cmd_i,
    input wire logic allow_rsvd_i,
    output logic [2:0] profile_pick_pins_o
);
    // reserved codes forced to 000
    // a reserved code only escapes when a refusal test asks for it
    assign profile_pick_pins_o = (pick_cmd_i[2:1] == 2'h3 && !allow_rsvd_i) ? 3'h0 : pick_cmd_i;
endmodule : cgc_board_model

// File: testbench/clock_gen_config_and_output_control_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench top
module clock_gen_config_and_output_control_tb_top;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] pick = 3'h0;
    logic [2:0] pins;
    logic allow = 1'b0, choice = 1'b0, pin = 1'b0, pfail = 1'b0, sfail = 1'b0;
    logic wr = 1'b0, vld = 1'b0, look = 1'b0;
    logic [2:0] widx = 3'h0;
    logic [6:0] addr = 7'h00;
    cgc_pkg::cgc_cfg_t wdata = cgc_pkg::CFG_RESET;
    cgc_pkg::cgc_cfg_t slot [6];
    cgc_pkg::cgc_cfg_t c;
    logic [2:0] prof_o;
    logic aux_o, osc_o, shut_o, match_o;
    cgc_pkg::cgc_out_ctl_t out_o;
    cgc_pkg::cgc_filter_t filt_o;
    logic [40:0] expq [$];
    int failures = 0, checks = 0, cyc = 0;

    always #2.5 mclk_i = ~mclk_i;

    cgc_board_model i_cgc_board_model (.pick_cmd_i(pick), .allow_rsvd_i(allow), .profile_pick_pins_o(pins));
    cgc_ctrl i_cgc_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .profile_pick_pins_i(pins),
        .source_choice_input_i(choice), .shutdown_enable_pin_i(pin), .primary_fail_i(pfail),
        .secondary_fail_i(sfail), .cfg_wr_i(wr), .cfg_wr_idx_i(widx), .cfg_wr_data_i(wdata),
        .host_addr_vld_i(vld), .host_addr_i(addr), .active_profile_o(prof_o), .ref_is_aux_o(aux_o),
        .crystal_osc_en_o(osc_o), .pll_shutdown_o(shut_o), .out_ctl_o(out_o), .filter_o(filt_o),
        .addr_match_o(match_o));

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task automatic compare(input logic [40:0] seen, input logic [40:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask : compare

    // expectation built from the pin truth table and filter weights
    function automatic logic [40:0] expect_v(logic [2:0] p, cgc_pkg::cgc_cfg_t k, logic ax, logic am);
        cgc_pkg::cgc_out_ctl_t o;
        cgc_pkg::cgc_filter_t f;
        for (int n = 0; n < cgc_pkg::NUM_OUT; n++) begin
            o.drive_en[n] = k.output_present_bit[n] | (k.pin_function_bit & pin);
            o.suspend[n] = (k.pin_function_bit & pin) | (k.output_present_bit[n] & k.output_gate_bit[n]
                & (pin != k.pin_polarity_bit));
        end
        f.loop_res_ohm = 17'(k.loop_resistor_code) * 17'h0_0fa0;
        f.pump_ua = 6'(k.pump_current_code) * 6'h06;
        f.zero_cap = k.zero_cap_bit;
        return {p, ax, ~k.crystal_bypass_bit, k.pin_function_bit & pin, o, f, am};
    endfunction : expect_v

    task automatic hold(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : hold

    task automatic wr_cfg(input logic [2:0] i, input cgc_pkg::cgc_cfg_t k);
        wr = 1'b1;
        widx = i;
        wdata = k;
        hold(1);
        wr = 1'b0;
        // one low edge between writes so the strobe never changes twice in one step
        hold(1);
        if (i < 3'h6) slot[i] = k;
    endtask : wr_cfg

    task automatic check(input logic [2:0] p, input logic ax, input logic am);
        expq.push_back(expect_v(p, slot[p], ax, am));
        look = 1'b1;
        hold(1);
        look = 1'b0;
    endtask : check

    // ==========================================
    // monitor: oldest note against what the outputs show
    always @(posedge mclk_i) begin
        cyc++;
        if (look) compare({prof_o, aux_o, osc_o, shut_o, out_o, filt_o, match_o}, expq.pop_front());
        // the scenarios need well under a thousand cycles
        if (cyc > 2000) begin
            failures++;
            results();
        end
    end

    initial begin
        void'($urandom(87718));
        foreach (slot[i]) slot[i] = cgc_pkg::CFG_RESET;
        hold(12);
        rst_i = 1'b0;
        hold(6);
        check(3'h0, 1'b0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            c = cgc_pkg::cgc_cfg_t'(24'($urandom));
            c.switchover_mode_field[1] = 1'b0;
            wr_cfg(3'(i), c);
        end
        for (int i = 0; i < 30; i++) begin
            pick = 3'(i % 6);
            choice = 1'($urandom);
            pin = 1'($urandom);
            hold(6);
            check(pick, choice ^ slot[pick].primary_source_bit, 1'b0);
        end
        allow = 1'b1;
        pick = 3'h6;
        hold(3);
        pick = 3'h7;
        hold(6);
        check(3'h5, choice ^ slot[5].primary_source_bit, 1'b0);
        allow = 1'b0;
        pick = 3'h5;
        c = cgc_pkg::cgc_cfg_t'(24'($urandom));
        c.switchover_mode_field = 2'h1;
        wr_cfg(3'h5, c);
        hold(2);
        check(3'h5, choice ^ c.primary_source_bit, 1'b0);
        for (int k = 0; k < 8; k++) begin
            vld = 1'b1;
            addr = (k % 3 == 0) ? cgc_pkg::DEV_ADDR : 7'($urandom);
            hold(1);
            vld = 1'b0;
            check(3'h5, choice ^ c.primary_source_bit, 1'(addr == cgc_pkg::DEV_ADDR));
        end
        pick = 3'h0;
        choice = 1'b0;
        c.primary_source_bit = 1'b0;
        c.switchover_mode_field = cgc_pkg::SW_AUTO;
        wr_cfg(3'h0, c);
        hold(6);
        check(3'h0, 1'b0, 1'b0);
        pfail = 1'b1;
        hold(6);
        check(3'h0, 1'b1, 1'b0);
        pfail = 1'b0;
        hold(6);
        check(3'h0, 1'b1, 1'b0);
        c.switchover_mode_field = 2'h3;
        wr_cfg(3'h0, c);
        sfail = 1'b1;
        hold(6);
        check(3'h0, 1'b0, 1'b0);
        hold(2);
        results();
    end
endmodule : clock_gen_config_and_output_control_tb_top
